// ### scb_setup_cmd.sv
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module scb_setup_cmd #(
  parameter int ROWS = 64
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        bias_reached_i,
  input  wire logic        bias_fail_i,
  output logic             bias_en_o,
  output logic             bias_zero_o,
  output logic      [31:0] bias_target_o,
  output logic             cal_busy_o,
  output logic      [7:0]  slot_o,
  output logic             slot_load_o,
  output logic             slot_save_o
);
  import scb_pkg::*;

  localparam int ROWW = $clog2(ROWS);

  typedef struct packed {
    scb_rx_st_t                  rst;
    logic [7:0]                  rtag, rlen, ropt, rcnt;
    logic                        rbad;
    logic [RBUF_BYTES-1:0][7:0]  rbuf;
    logic                        rx_ready;
    scb_tx_ph_t                  tph;
    scb_kind_t                   tkind;
    logic [7:0]                  ttag, tlen, topt, tcode, tcnt, tidx;
    logic [15:0]                 trow, trem;
    logic                        tack, tval;
    logic [7:0]                  tdat;
    scb_cal_t                    cst;
    logic                        load_set, cal_abort, cal_done, req_pend;
    logic [7:0]                  load_kind, cal_ch;
    logic [31:0]                 load_val;
    logic [15:0]                 cal_cnt, cal_row;
    scb_bias_t                   bst;
    logic [31:0]                 bias_val;
    logic [15:0]                 bcnt;
    logic                        bok_pend, bng_pend;
    logic                        bias_en, bias_zero, cal_busy;
    logic [7:0]                  slot;
    logic                        slot_load, slot_save;
    logic                        ack;
    logic [31:0]                 dat;
    logic [15:0]                 rowcnt, tbl_idx;
  } scb_st_t;

  scb_st_t     s;
  scb_st_t     next_s;
  logic [31:0] tbl [ROWS][3];
  logic        tbl_we;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [31:0] dw;
  logic [15:0] lrow;
  logic [7:0]  take;
  logic        ok;
  logic        rep;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] word_at(
    input logic [RBUF_BYTES-1:0][7:0] b,
    input int                         k
  );
    return {b[k], b[k+1], b[k+2], b[k+3]};
  endfunction

  function automatic logic [7:0] msb_byte(
    input logic [31:0] w,
    input logic [1:0]  i
  );
    return w[(5'd24 - {i, 3'b000}) +: 8];
  endfunction

  // Frame holds at most LIST_MAX floats
  function automatic logic [7:0] list_take(input logic [15:0] r);
    return (r > 16'(LIST_MAX)) ? LIST_MAX : r[7:0];
  endfunction

  assign lrow = s.trow + 16'(s.tidx[7:2]);

  always_comb begin
    case (s.tkind)
      K_CNT:   dw = {s.rowcnt, 16'h0000};
      K_PT:    dw = tbl[s.trow[ROWW-1:0]][s.tidx[3:2]];
      K_LIST:  dw = tbl[lrow[ROWW-1:0]][0];
      default: dw = s.bias_val;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    take   = 8'h00;
    ok     = 1'b0;
    rep    = 1'b0;
    next_s.slot_load = 1'b0;
    next_s.slot_save = 1'b0;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wdata = (tbl[s.tbl_idx[ROWW+1:2]][s.tbl_idx[1:0]] & ~wmask)
          | (wb_dat_i & wmask);
    tbl_we = 1'b0;

    // Bus slave, one wait state
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (next_s.ack) begin
      next_s.dat = 32'h0000_0000;
      if (wb_adr_i == REG_STATUS) begin
        next_s.dat = {s.cal_cnt, s.slot, 1'b0, s.cal_done, s.cal_abort,
                      s.load_set, s.bst, s.cst};
      end else if (wb_adr_i == REG_ROWCNT) begin
        next_s.dat = {16'h0000, s.rowcnt};
        if (wb_we_i) begin
          next_s.rowcnt = (s.rowcnt & ~wmask[15:0])
                        | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == REG_TBL_IDX) begin
        next_s.dat = {16'h0000, s.tbl_idx};
        if (wb_we_i) begin
          next_s.tbl_idx = (s.tbl_idx & ~wmask[15:0])
                         | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == REG_TBL_DATA) begin
        // Word index 3 is a hole in the table
        if (s.tbl_idx[1:0] != 2'd3) begin
          next_s.dat = tbl[s.tbl_idx[ROWW+1:2]][s.tbl_idx[1:0]];
          tbl_we = wb_we_i;
        end
      end else if (wb_adr_i == REG_LOAD_VAL) begin
        next_s.dat = s.load_val;
      end else if (wb_adr_i == REG_BIAS_VAL) begin
        next_s.dat = s.bias_val;
      end else if (wb_adr_i == REG_CAL_INFO) begin
        next_s.dat = {s.load_kind, s.cal_ch, s.cal_row};
      end
    end

    // Transmit sequencer, one byte per accepted beat
    if (!s.tval || tx_ready_i) begin
      next_s.tval = 1'b1;
      case (s.tph)
        T_TAG: begin
          next_s.tdat = s.ttag;
          next_s.tph  = T_LEN;
        end
        T_LEN: begin
          next_s.tdat = s.tlen;
          next_s.tph  = T_OPT;
        end
        T_OPT: begin
          next_s.tdat = s.topt;
          next_s.tidx = 8'h00;
          next_s.tph  = (s.tcnt == 8'h00) ? T_END : T_DAT;
        end
        T_DAT: begin
          next_s.tdat = msb_byte(dw, s.tidx[1:0]);
          next_s.tidx = s.tidx + 8'd1;
          if (s.tidx == s.tcnt - 8'd1) begin
            next_s.tph = T_END;
          end
        end
        T_END: begin
          next_s.tdat = s.ttag;
          if (s.tkind == K_LIST && s.trem != 16'h0000) begin
            take = list_take(s.trem);
            next_s.trow = s.trow + 16'(s.tcnt[7:2]);
            next_s.tcnt = {take[5:0], 2'b00};
            next_s.tlen = {take[5:0], 2'b00} + 8'd1;
            next_s.trem = s.trem - 16'(take);
            next_s.tph  = T_TAG;
          end else begin
            next_s.tph = s.tack ? T_ACK : T_IDLE;
          end
        end
        T_ACK: begin
          next_s.tdat = s.tcode;
          next_s.tph  = T_IDLE;
        end
        default: next_s.tval = 1'b0;
      endcase
    end

    // Unsolicited frames, only between command replies
    if (s.tph == T_IDLE && s.rst != R_EXEC) begin
      next_s.ttag  = TAG_CFG;
      next_s.tlen  = LEN_BARE;
      next_s.tcnt  = 8'h00;
      next_s.tkind = K_NONE;
      next_s.tack  = 1'b0;
      if (s.req_pend) begin
        next_s.req_pend = 1'b0;
        next_s.ttag = TAG_GET;
        next_s.topt = (s.cst == C_OPEN)  ? OPT_REQ_OPEN :
                      (s.cst == C_SHORT) ? OPT_REQ_SHORT :
                      OPT_REQ_LOAD;
        if (s.cst != C_IDLE) begin
          next_s.tph = T_TAG;
        end
      end else if (s.bok_pend) begin
        next_s.bok_pend = 1'b0;
        next_s.topt = OPT_BIAS_OK;
        next_s.tph  = T_TAG;
      end else if (s.bng_pend) begin
        next_s.bng_pend = 1'b0;
        next_s.topt = OPT_BIAS_NG;
        next_s.tph  = T_TAG;
      end
    end

    // Bias regulation; a new result wins over a flag just sent
    case (s.bst)
      B_ZERO: begin
        next_s.bcnt = s.bcnt + 16'd1;
        if (s.bcnt == BIAS_ZERO_CYC - 16'd1) begin
          next_s.bst = B_REG;
        end
      end
      B_REG: begin
        if (bias_reached_i) begin
          next_s.bst      = B_ON;
          next_s.bok_pend = 1'b1;
        end else if (bias_fail_i) begin
          next_s.bst      = B_OFF;
          next_s.bng_pend = 1'b1;
        end
      end
      default: ;
    endcase

    // Frame receiver
    if (s.rx_ready && rx_valid_i) begin
      case (s.rst)
        R_TAG: begin
          if (rx_data_i == TAG_CFG || rx_data_i == TAG_GET) begin
            next_s.rtag = rx_data_i;
            next_s.rst  = R_LEN;
          end
        end
        R_LEN: begin
          next_s.rlen = rx_data_i;
          next_s.rcnt = 8'h00;
          next_s.rbad = (rx_data_i == 8'h00);
          next_s.rst  = (rx_data_i == 8'h00) ? R_END : R_OPT;
        end
        R_OPT: begin
          next_s.ropt = rx_data_i;
          next_s.rst  = (s.rlen == LEN_BARE) ? R_END : R_DATA;
        end
        R_DATA: begin
          if (s.rcnt < 8'(RBUF_BYTES)) begin
            next_s.rbuf[s.rcnt[4:0]] = rx_data_i;
          end else begin
            next_s.rbad = 1'b1;
          end
          next_s.rcnt = s.rcnt + 8'd1;
          if (s.rcnt == s.rlen - 8'd2) begin
            next_s.rst = R_END;
          end
        end
        R_END: begin
          if (rx_data_i != s.rtag) begin
            next_s.rbad = 1'b1;
          end
          next_s.rst = R_EXEC;
        end
        default: ;
      endcase
    end

    // Command execution once the transmitter is free
    if (s.rst == R_EXEC && s.tph == T_IDLE) begin
      next_s.rst   = R_TAG;
      next_s.ttag  = s.rtag;
      next_s.topt  = s.ropt;
      next_s.tkind = K_NONE;
      next_s.tcnt  = 8'h00;
      if (!s.rbad && s.rtag == TAG_CFG) begin
        case (s.ropt)
          OPT_CAL_GO: begin
            ok = s.rlen == LEN_BARE && s.cst == C_IDLE;
            if (ok) begin
              next_s.cst       = C_OPEN;
              next_s.req_pend  = 1'b1;
              next_s.cal_abort = 1'b0;
              next_s.cal_done  = 1'b0;
            end
          end
          OPT_CAL_OK: begin
            ok = s.rlen == LEN_BARE && s.cst != C_IDLE
              && (s.cst != C_LOAD || s.load_set);
            if (ok) begin
              next_s.req_pend = (s.cst != C_LOAD);
              next_s.cal_done = (s.cst == C_LOAD);
              next_s.cst = (s.cst == C_OPEN)  ? C_SHORT :
                           (s.cst == C_SHORT) ? C_LOAD : C_IDLE;
            end
          end
          OPT_CAL_NG: begin
            ok = s.rlen == LEN_BARE && s.cst != C_IDLE;
            if (ok) begin
              next_s.cst       = C_IDLE;
              next_s.cal_abort = 1'b1;
            end
          end
          OPT_LOAD: begin
            ok = s.rlen == LEN_LOAD
              && (s.rbuf[0] == LOAD_RES || s.rbuf[0] == LOAD_CAP);
            if (ok) begin
              next_s.load_kind = s.rbuf[0];
              next_s.load_val  = word_at(s.rbuf, 1);
              next_s.load_set  = 1'b1;
            end
          end
          OPT_CALDAT: begin
            if (s.rlen == LEN_BYTE && s.rbuf[0] == SUB_CAL_CLR) begin
              ok = 1'b1;
              next_s.cal_cnt = 16'h0000;
            end else if (s.rlen == LEN_CALDAT
                         && s.rbuf[0] == SUB_CAL_SET) begin
              ok = 1'b1;
              next_s.cal_ch  = s.rbuf[1];
              next_s.cal_row = {s.rbuf[2], s.rbuf[3]};
              next_s.cal_cnt = s.cal_cnt + 16'd1;
            end
          end
          OPT_SLOT: begin
            ok = s.rlen == LEN_BYTE && s.rbuf[0] != 8'h00;
            if (ok) begin
              next_s.slot      = s.rbuf[0];
              next_s.slot_load = 1'b1;
            end
          end
          OPT_BIAS: begin
            ok = s.rlen == LEN_BYTE
              && (s.rbuf[0] == BIAS_ON || s.rbuf[0] == BIAS_OFF);
            if (ok) begin
              next_s.bok_pend = 1'b0;
              next_s.bng_pend = 1'b0;
              next_s.bcnt     = 16'h0000;
              next_s.bst = (s.rbuf[0] == BIAS_ON) ? B_ZERO : B_OFF;
            end
          end
          OPT_BIAS_NG: begin
            ok = s.rlen == LEN_BARE;
            if (ok && (s.bst == B_ZERO || s.bst == B_REG)) begin
              next_s.bst = B_OFF;
            end
          end
          OPT_BIAS_VAL: begin
            ok = s.rlen == LEN_FLOAT;
            if (ok) begin
              next_s.bias_val = word_at(s.rbuf, 0);
            end
          end
          default: ok = 1'b0;
        endcase
      end else if (!s.rbad) begin
        case (s.ropt)
          OPT_CNT: begin
            ok  = s.rlen == LEN_BARE;
            rep = ok;
            next_s.tkind = K_CNT;
            next_s.tlen  = LEN_ROW;
            next_s.tcnt  = LEN_ROW - 8'd1;
          end
          OPT_PT: begin
            ok  = s.rlen == LEN_ROW
               && {s.rbuf[0], s.rbuf[1]} < s.rowcnt;
            rep = ok;
            next_s.tkind = K_PT;
            next_s.trow  = {s.rbuf[0], s.rbuf[1]};
            next_s.tlen  = LEN_POINT;
            next_s.tcnt  = LEN_POINT - 8'd1;
          end
          OPT_LIST: begin
            ok   = s.rlen == LEN_BARE;
            rep  = ok;
            take = list_take(s.rowcnt);
            next_s.tkind = K_LIST;
            next_s.trow  = 16'h0000;
            next_s.tcnt  = {take[5:0], 2'b00};
            next_s.tlen  = {take[5:0], 2'b00} + 8'd1;
            next_s.trem  = s.rowcnt - 16'(take);
          end
          OPT_SLOT: begin
            ok = s.rlen == LEN_BYTE && s.rbuf[0] != 8'h00;
            if (ok) begin
              next_s.slot      = s.rbuf[0];
              next_s.slot_save = 1'b1;
            end
          end
          OPT_BIAS_VAL: begin
            ok  = s.rlen == LEN_BARE;
            rep = ok;
            next_s.tkind = K_NONE;
            next_s.tlen  = LEN_FLOAT;
            next_s.tcnt  = LEN_FLOAT - 8'd1;
          end
          default: ok = 1'b0;
        endcase
      end
      next_s.tcode = ok ? ACK_BYTE : NAK_BYTE;
      next_s.tack  = 1'b1;
      next_s.tph   = rep ? T_TAG : T_ACK;
    end
    next_s.rx_ready = (next_s.rst != R_EXEC);
    // Status pins registered so they leave straight from flops
    next_s.bias_en   = (next_s.bst != B_OFF);
    next_s.bias_zero = (next_s.bst == B_ZERO);
    next_s.cal_busy  = (next_s.cst != C_IDLE);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.rowcnt <= ROWCNT_RST;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (tbl_we) begin
      tbl[s.tbl_idx[ROWW+1:2]][s.tbl_idx[1:0]] <= wdata;
    end
  end

  assign wb_dat_o      = s.dat;
  assign wb_ack_o      = s.ack;
  assign rx_ready_o    = s.rx_ready;
  assign tx_valid_o    = s.tval;
  assign tx_data_o     = s.tdat;
  assign bias_en_o     = s.bias_en;
  assign bias_zero_o   = s.bias_zero;
  assign bias_target_o = s.bias_val;
  assign cal_busy_o    = s.cal_busy;
  assign slot_o        = s.slot;
  assign slot_load_o   = s.slot_load;
  assign slot_save_o   = s.slot_save;

endmodule

// ### scb_pkg.sv
package scb_pkg;

  // ****************************************
  // Framing
  // ****************************************
  localparam logic [7:0] TAG_CFG  = 8'hb6;
  localparam logic [7:0] TAG_GET  = 8'hb7;
  localparam logic [7:0] ACK_BYTE = 8'h83;
  localparam logic [7:0] NAK_BYTE = 8'h84;

  localparam logic [7:0] OPT_CNT       = 8'h01;
  localparam logic [7:0] OPT_PT        = 8'h02;
  localparam logic [7:0] OPT_LIST      = 8'h04;
  localparam logic [7:0] OPT_CAL_GO    = 8'h10;
  localparam logic [7:0] OPT_CAL_OK    = 8'h11;
  localparam logic [7:0] OPT_CAL_NG    = 8'h12;
  localparam logic [7:0] OPT_REQ_OPEN  = 8'h13;
  localparam logic [7:0] OPT_REQ_SHORT = 8'h14;
  localparam logic [7:0] OPT_REQ_LOAD  = 8'h15;
  localparam logic [7:0] OPT_LOAD      = 8'h16;
  localparam logic [7:0] OPT_CALDAT    = 8'h17;
  localparam logic [7:0] OPT_SLOT      = 8'h20;
  localparam logic [7:0] OPT_BIAS      = 8'h30;
  localparam logic [7:0] OPT_BIAS_OK   = 8'h31;
  localparam logic [7:0] OPT_BIAS_NG   = 8'h32;
  localparam logic [7:0] OPT_BIAS_VAL  = 8'h33;

  localparam logic [7:0] LEN_BARE   = 8'd1;
  localparam logic [7:0] LEN_BYTE   = 8'd2;
  localparam logic [7:0] LEN_ROW    = 8'd3;
  localparam logic [7:0] LEN_FLOAT  = 8'd5;
  localparam logic [7:0] LEN_LOAD   = 8'd6;
  localparam logic [7:0] LEN_POINT  = 8'd13;
  localparam logic [7:0] LEN_CALDAT = 8'd29;

  localparam logic [7:0] SUB_CAL_CLR = 8'h01;
  localparam logic [7:0] SUB_CAL_SET = 8'h02;
  localparam logic [7:0] LOAD_RES    = 8'h01;
  localparam logic [7:0] LOAD_CAP    = 8'h02;
  localparam logic [7:0] BIAS_ON     = 8'h01;
  localparam logic [7:0] BIAS_OFF    = 8'h02;

  localparam int         FRAME_MAX_DATA = 255;
  localparam logic [7:0] LIST_MAX = 8'((FRAME_MAX_DATA - 1) / 4);
  localparam int         RBUF_BYTES = 28;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_NS       = 8;
  localparam int          BIAS_ZERO_NS = 1000;
  localparam logic [15:0] BIAS_ZERO_CYC =
    16'((BIAS_ZERO_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  REG_STATUS   = 8'h00;
  localparam logic [7:0]  REG_ROWCNT   = 8'h04;
  localparam logic [7:0]  REG_TBL_IDX  = 8'h08;
  localparam logic [7:0]  REG_TBL_DATA = 8'h0c;
  localparam logic [7:0]  REG_LOAD_VAL = 8'h10;
  localparam logic [7:0]  REG_BIAS_VAL = 8'h14;
  localparam logic [7:0]  REG_CAL_INFO = 8'h18;
  localparam logic [15:0] ROWCNT_RST   = 16'h0000;

  typedef enum logic [2:0] {
    R_TAG, R_LEN, R_OPT, R_DATA, R_END, R_EXEC
  } scb_rx_st_t;
  typedef enum logic [2:0] {
    T_IDLE, T_TAG, T_LEN, T_OPT, T_DAT, T_END, T_ACK
  } scb_tx_ph_t;
  typedef enum logic [1:0] {K_NONE, K_CNT, K_PT, K_LIST} scb_kind_t;
  typedef enum logic [1:0] {C_IDLE, C_OPEN, C_SHORT, C_LOAD} scb_cal_t;
  typedef enum logic [1:0] {B_OFF, B_ZERO, B_REG, B_ON} scb_bias_t;

endpackage

// ### scb_setup_cmd_assertions.sv
`timescale 1ns/100ps
// **********
// Port checks
// **********
module scb_setup_cmd_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       tx_ready_i,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       bias_en_o,
  input wire logic       bias_zero_o,
  input wire logic       cal_busy_o,
  input wire logic [7:0] slot_o,
  input wire logic       slot_load_o,
  input wire logic       slot_save_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_wait: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_bias_zero_first: assert property (
    $rose(bias_en_o) |-> bias_zero_o)
    else $error("bias enabled without zero phase");
  a_zero_inside_en: assert property (
    bias_zero_o |-> bias_en_o)
    else $error("zero phase while bias disabled");
  a_zero_hold: assert property (
    $rose(bias_zero_o) |=> bias_zero_o [*4])
    else $error("zero phase cut short");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte dropped before acceptance");
  a_slot_valid: assert property (
    slot_load_o || slot_save_o |-> slot_o != 8'h00)
    else $error("slot zero used");
  a_slot_pulse: assert property (
    slot_load_o |=> !slot_load_o && !slot_save_o)
    else $error("slot load pulse too long");
  c_slot: cover property (slot_load_o);
  c_zero: cover property ($rose(bias_zero_o));
  c_cal_end: cover property ($fell(cal_busy_o));
endmodule

bind scb_setup_cmd scb_setup_cmd_chk u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_ready_i,
  .tx_valid_o, .tx_data_o, .bias_en_o, .bias_zero_o, .cal_busy_o,
  .slot_o, .slot_load_o, .slot_save_o
);

// ### scb_host_model.sv
`timescale 1ns/100ps
// **********
// Host side of the byte link
// **********
module scb_host_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end
  // Slow sink toggles ready so the device must hold each byte
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
  task automatic send(input logic [7:0] s[$]);
    foreach (s[i]) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= s[i];
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    // Released data line must not keep showing the last byte
    rx_data_o  <= ~rx_data_o;
  endtask
endmodule

// ### scb_setup_cmd_tb_top.sv
`timescale 1ns/100ps
module scb_setup_cmd_tb_top;
  import scb_pkg::*;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, slow;
  logic        b_ok, b_ng, rx_v, rx_r, tx_v, tx_r, b_en, b_zero;
  logic        cal_busy, s_ld, s_sv;
  logic [7:0]  wb_adr, rx_d, tx_d, slot;
  logic [31:0] wb_wdat, wb_rdat, rd, b_tgt;
  logic [7:0]  q[$], e[$];
  int          fails, checked, n_ld, n_sv;

  scb_setup_cmd uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_ready_o(rx_r),
    .tx_ready_i(tx_r), .tx_valid_o(tx_v), .tx_data_o(tx_d),
    .bias_reached_i(b_ok), .bias_fail_i(b_ng), .bias_en_o(b_en),
    .bias_zero_o(b_zero), .bias_target_o(b_tgt), .cal_busy_o(cal_busy),
    .slot_o(slot), .slot_load_o(s_ld), .slot_save_o(s_sv));
  scb_host_model host (
    .clk_i(clk_i), .slow_i(slow), .rx_ready_i(rx_r), .rx_valid_o(rx_v),
    .rx_data_o(rx_d), .tx_valid_i(tx_v), .tx_data_i(tx_d),
    .tx_ready_o(tx_r));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Slot strobes last one cycle, so count them as they pass
  always @(posedge clk_i) begin
    if (s_ld === 1'b1) n_ld <= n_ld + 1;
    if (s_sv === 1'b1) n_sv <= n_sv + 1;
  end
  // **********
  // Shared tasks
  // **********
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task go;
    int n;
    n = 0;
    host.send(q);
    while (host.got.size() < e.size() && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (6) @(posedge clk_i);
    chk("tx count", e.size(), host.got.size());
    if (host.got.size() == e.size())
      foreach (e[i]) chk("tx byte", {24'h0, e[i]}, {24'h0, host.got[i]});
    host.got.delete();
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  // **********
  // Tests
  // **********
  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    slow = 1'b0;
    b_ok = 1'b0;
    b_ng = 1'b0;
    fails = 0;
    checked = 0;
    n_ld = 0;
    n_sv = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_ROWCNT, 32'h0);
    chk("rowcnt reset", {16'h0, ROWCNT_RST}, rd);
    wb(1'b1, REG_ROWCNT, 32'h5);
    wb(1'b0, REG_ROWCNT, 32'h0);
    chk("rowcnt", 32'h5, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    slow <= 1'b1;
    q = {8'hb7, 8'h01, 8'h01, 8'hb7};
    e = {8'hb7, 8'h03, 8'h01, 8'h00, 8'h05, 8'hb7, 8'h83};
    go();
    q = {8'hb6, 8'h05, 8'h33, 8'h3f, 8'h80, 8'h00, 8'h00, 8'hb6};
    e = {8'h83};
    go();
    chk("bias target", 32'h3f800000, b_tgt);
    q = {8'hb7, 8'h01, 8'h33, 8'hb7};
    e = {8'hb7, 8'h05, 8'h33, 8'h3f, 8'h80, 8'h00, 8'h00, 8'hb7, 8'h83};
    go();
    q = {8'hb6, 8'h02, 8'h30, 8'h01, 8'hb6};
    e = {8'h83};
    go();
    chk("bias zero", 32'h1, {31'h0, b_zero});
    repeat (BIAS_ZERO_CYC + 16'd10) @(posedge clk_i);
    chk("zero ended", 32'h0, {31'h0, b_zero});
    b_ok <= 1'b1;
    q = {};
    e = {8'hb6, 8'h01, 8'h31, 8'hb6};
    go();
    b_ok <= 1'b0;
    q = {8'hb6, 8'h02, 8'h30, 8'h02, 8'hb6};
    e = {8'h83};
    go();
    chk("bias off", 32'h0, {31'h0, b_en});
    q = {8'hb6, 8'h02, 8'h30, 8'h01, 8'hb6};
    e = {8'h83};
    go();
    repeat (BIAS_ZERO_CYC + 16'd10) @(posedge clk_i);
    b_ng <= 1'b1;
    q = {};
    e = {8'hb6, 8'h01, 8'h32, 8'hb6};
    go();
    b_ng <= 1'b0;
    q = {8'hb6, 8'h02, 8'h30, 8'h01, 8'hb6};
    e = {8'h83};
    go();
    q = {8'hb6, 8'h01, 8'h32, 8'hb6};
    go();
    chk("bias aborted", 32'h0, {31'h0, b_en});
    $display("test bias done");
    q = {8'hb6, 8'h01, 8'h10, 8'hb6};
    e = {8'h83, 8'hb7, 8'h01, 8'h13, 8'hb7};
    go();
    chk("cal busy", 32'h1, {31'h0, cal_busy});
    q = {8'hb6, 8'h01, 8'h11, 8'hb6};
    e = {8'h83, 8'hb7, 8'h01, 8'h14, 8'hb7};
    go();
    e = {8'h83, 8'hb7, 8'h01, 8'h15, 8'hb7};
    go();
    e = {8'h84};
    go();
    q = {8'hb6, 8'h06, 8'h16, 8'h01, 8'h44, 8'h7a, 8'h00, 8'h00, 8'hb6};
    e = {8'h83};
    go();
    wb(1'b0, REG_LOAD_VAL, 32'h0);
    chk("load value", 32'h447a0000, rd);
    q = {8'hb6, 8'h01, 8'h11, 8'hb6};
    go();
    chk("cal done", 32'h0, {31'h0, cal_busy});
    q = {8'hb6, 8'h01, 8'h10, 8'hb6};
    e = {8'h83, 8'hb7, 8'h01, 8'h13, 8'hb7};
    go();
    q = {8'hb6, 8'h01, 8'h12, 8'hb6};
    e = {8'h83};
    go();
    chk("cal aborted", 32'h0, {31'h0, cal_busy});
    q = {8'hb6, 8'h1d, 8'h17, 8'h02, 8'h03, 8'h00, 8'h04};
    repeat (24) q.push_back(8'h11);
    q.push_back(8'hb6);
    go();
    wb(1'b0, REG_CAL_INFO, 32'h0);
    chk("cal info", 32'h01030004, rd);
    q = {8'hb6, 8'h02, 8'h17, 8'h01, 8'hb6};
    go();
    wb(1'b0, REG_STATUS, 32'h0);
    chk("cal count", 32'h0, {16'h0, rd[31:16]});
    $display("test calibration done");
    q = {8'hb6, 8'h01, 8'h55, 8'hb6};
    e = {8'h84};
    go();
    q = {8'hb6, 8'h02, 8'h20, 8'h00, 8'hb6};
    go();
    q = {8'hb6, 8'h02, 8'h20, 8'h05, 8'hb6};
    e = {8'h83};
    go();
    chk("slot", 32'h5, {24'h0, slot});
    q = {8'hb7, 8'h02, 8'h20, 8'h07, 8'hb7};
    go();
    chk("saved slot", 32'h7, {24'h0, slot});
    chk("slot loads", 32'h1, n_ld);
    chk("slot saves", 32'h1, n_sv);
    $display("test slots done");
    wb(1'b1, REG_TBL_IDX, 32'h0);
    wb(1'b1, REG_TBL_DATA, 32'h46fa0000);
    wb(1'b1, REG_TBL_IDX, 32'h1);
    wb(1'b1, REG_TBL_DATA, 32'h3f800000);
    wb(1'b1, REG_TBL_IDX, 32'h2);
    wb(1'b1, REG_TBL_DATA, 32'h3e800000);
    wb(1'b0, REG_TBL_DATA, 32'h0);
    chk("table word", 32'h3e800000, rd);
    wb(1'b1, REG_ROWCNT, 32'h1);
    q = {8'hb7, 8'h03, 8'h02, 8'h00, 8'h00, 8'hb7};
    e = {8'hb7, 8'h0d, 8'h02, 8'h46, 8'hfa, 8'h00, 8'h00, 8'h3f, 8'h80,
         8'h00, 8'h00, 8'h3e, 8'h80, 8'h00, 8'h00, 8'hb7, 8'h83};
    go();
    q = {8'hb7, 8'h01, 8'h04, 8'hb7};
    e = {8'hb7, 8'h05, 8'h04, 8'h46, 8'hfa, 8'h00, 8'h00, 8'hb7, 8'h83};
    go();
    $display("test readback done");
    complete_run();
  end
endmodule
